// File: cto_clock_lane_timing.sv
// Clock-lane timing override registers and the clock-lane entry/exit sequencer.
// Assumes a same-clock register master and a same-clock high-speed clock request.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module cto_clock_lane_timing (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input cto_pkg::cto_bus_req_t bus_i,
  output logic [7:0] bus_rdata_o,
  input wire logic [2:0] lane_rate_i,
  input wire logic hs_clk_req_i,
  output cto_pkg::cto_ivl_set_t timing_o,
  output logic clk_lp_zero_o,
  output logic clk_hs_drive_o,
  output logic clk_toggle_en_o
);

  cto_pkg::cto_state_t state_reg;
  cto_pkg::cto_state_t state_next;
  cto_pkg::cto_ivl_set_t auto_ivl;
  cto_pkg::cto_ivl_set_t eff_ivl;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [6:0] cur_limit;
  logic cur_done;

  cto_auto_timing u_auto (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .rate_i(lane_rate_i),
    .auto_o(auto_ivl)
  );

  // Effective intervals are a pure mux of flops, so they never glitch on a bus write.
  always_comb
  begin
    for (int i = 0; i < cto_pkg::CTO_NUM_IVL; i++)
    begin
      eff_ivl[i] = state_reg.ivl[i].override ? state_reg.ivl[i].value : auto_ivl[i];
    end
  end

  assign wr_idx = cto_pkg::cto_addr_index(bus_i.addr);
  assign rd_idx = cto_pkg::cto_addr_index(bus_i.addr);

  // A zero interval would stall no state at all, so it is held for one cycle.
  always_comb
  begin
    cur_limit = 7'h01;
    unique case (state_reg.seq)
      cto_pkg::CTO_SEQ_PREPARE: cur_limit = eff_ivl[cto_pkg::CTO_IDX_PREPARE];
      cto_pkg::CTO_SEQ_ZERO: cur_limit = eff_ivl[cto_pkg::CTO_IDX_ZERO];
      cto_pkg::CTO_SEQ_TRAIL: cur_limit = eff_ivl[cto_pkg::CTO_IDX_TRAIL];
      cto_pkg::CTO_SEQ_IDLE, cto_pkg::CTO_SEQ_HS: cur_limit = 7'h01;
      default: cur_limit = 7'h01;
    endcase
    if (cur_limit == 7'h00)
    begin
      cur_limit = 7'h01;
    end
    cur_done = ({1'b0, state_reg.cnt} + 8'h01) >= {1'b0, cur_limit};
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = cto_pkg::CTO_READ_UNMAPPED;
    // The override bit is taken first, so one write can set override and value together.
    if (bus_i.wr && (wr_idx != cto_pkg::CTO_IDX_NONE))
    begin
      state_next.ivl[wr_idx].override = bus_i.wdata[cto_pkg::CTO_OVERRIDE_BIT];
      if (bus_i.wdata[cto_pkg::CTO_OVERRIDE_BIT])
      begin
        state_next.ivl[wr_idx].value = bus_i.wdata[6:0];
      end
      else
      begin
        state_next.ivl[wr_idx].value = state_reg.ivl[wr_idx].value;
      end
    end
    if (bus_i.rd && (rd_idx != cto_pkg::CTO_IDX_NONE))
    begin
      state_next.rdata = {state_reg.ivl[rd_idx].override, eff_ivl[rd_idx]};
    end

    state_next.cnt = cur_done ? 7'h00 : 7'(state_reg.cnt + 7'h01);
    unique case (state_reg.seq)
      cto_pkg::CTO_SEQ_IDLE:
      begin
        state_next.cnt = 7'h00;
        if (hs_clk_req_i)
        begin
          state_next.seq = cto_pkg::CTO_SEQ_PREPARE;
        end
      end
      cto_pkg::CTO_SEQ_PREPARE:
      begin
        if (cur_done)
        begin
          state_next.seq = cto_pkg::CTO_SEQ_ZERO;
        end
      end
      cto_pkg::CTO_SEQ_ZERO:
      begin
        if (cur_done)
        begin
          state_next.seq = cto_pkg::CTO_SEQ_HS;
        end
      end
      cto_pkg::CTO_SEQ_HS:
      begin
        state_next.cnt = 7'h00;
        if (!hs_clk_req_i)
        begin
          state_next.seq = cto_pkg::CTO_SEQ_TRAIL;
        end
      end
      cto_pkg::CTO_SEQ_TRAIL:
      begin
        if (cur_done)
        begin
          state_next.seq = cto_pkg::CTO_SEQ_IDLE;
        end
      end
      default:
      begin
        state_next.seq = cto_pkg::CTO_SEQ_IDLE;
        state_next.cnt = 7'h00;
      end
    endcase
    state_next.lp_zero = (state_next.seq == cto_pkg::CTO_SEQ_PREPARE);
    state_next.hs_drive = (state_next.seq == cto_pkg::CTO_SEQ_ZERO) ||
      (state_next.seq == cto_pkg::CTO_SEQ_HS) || (state_next.seq == cto_pkg::CTO_SEQ_TRAIL);
    state_next.toggle_en = (state_next.seq == cto_pkg::CTO_SEQ_HS);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < cto_pkg::CTO_NUM_IVL; i++)
      begin
        state_reg.ivl[i].override <= 1'b0;
        state_reg.ivl[i].value <= cto_pkg::CTO_RESET_IVL[i];
      end
      state_reg.rdata <= cto_pkg::CTO_READ_UNMAPPED;
      state_reg.seq <= cto_pkg::CTO_SEQ_IDLE;
      state_reg.cnt <= 7'h00;
      state_reg.lp_zero <= 1'b0;
      state_reg.hs_drive <= 1'b0;
      state_reg.toggle_en <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata_o = state_reg.rdata;
  assign timing_o = eff_ivl;
  assign clk_lp_zero_o = state_reg.lp_zero;
  assign clk_hs_drive_o = state_reg.hs_drive;
  assign clk_toggle_en_o = state_reg.toggle_en;

  property p_prepare_override;
    @(posedge clock_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == cto_pkg::CTO_ADDR_CLK_PREPARE && bus_i.wdata[7])
      |=> timing_o[0] == $past(bus_i.wdata[6:0]);
  endproperty
  a_prepare_override: assert property (p_prepare_override)
    else $error("Prepare override value not applied.");

  property p_zero_override;
    @(posedge clock_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == cto_pkg::CTO_ADDR_CLK_ZERO && bus_i.wdata[7])
      |=> timing_o[1] == $past(bus_i.wdata[6:0]);
  endproperty
  a_zero_override: assert property (p_zero_override)
    else $error("Zero override value not applied.");

  property p_trail_auto;
    @(posedge clock_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == cto_pkg::CTO_ADDR_CLK_TRAIL && !bus_i.wdata[7])
      |=> timing_o[2] == auto_ivl[2];
  endproperty
  a_trail_auto: assert property (p_trail_auto)
    else $error("Trail interval not automatic with override clear.");

  property p_write_ignored;
    @(posedge clock_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == cto_pkg::CTO_ADDR_CLK_ZERO && !bus_i.wdata[7])
      ##1 (ce_i && bus_i.rd && bus_i.addr == cto_pkg::CTO_ADDR_CLK_ZERO)
      |=> bus_rdata_o == {1'b0, $past(auto_ivl[1])};
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("Zero readback not automatic after non-override write.");

  property p_readback;
    @(posedge clock_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == cto_pkg::CTO_ADDR_CLK_PREPARE && bus_i.wdata[7])
      ##1 (ce_i && bus_i.rd && bus_i.addr == cto_pkg::CTO_ADDR_CLK_PREPARE)
      |=> bus_rdata_o == {1'b1, $past(bus_i.wdata[6:0], 2)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("Override value not read back as written.");

  property p_rate_follow;
    @(posedge clock_i) disable iff (reset_i)
    ($past(ce_i) && !$past(reset_i)) |-> auto_ivl == cto_pkg::cto_auto_lookup($past(lane_rate_i));
  endproperty
  a_rate_follow: assert property (p_rate_follow)
    else $error("Automatic intervals do not follow lane rate.");

  property p_reset_values;
    @(posedge clock_i) disable iff (reset_i)
    $past(reset_i) |-> (timing_o == {7'h0b, 7'h1b, 7'h05}) &&
      !state_reg.ivl[0].override && !state_reg.ivl[1].override && !state_reg.ivl[2].override;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Wrong values after reset.");

  property p_prepare_bound;
    @(posedge clock_i) disable iff (reset_i)
    (state_reg.seq == cto_pkg::CTO_SEQ_PREPARE) |->
      ({1'b0, state_reg.cnt} < {1'b0, cur_limit});
  endproperty
  a_prepare_bound: assert property (p_prepare_bound)
    else $error("Prepare state outlasts its interval.");

  property p_trail_exit;
    @(posedge clock_i) disable iff (reset_i)
    (ce_i && state_reg.seq == cto_pkg::CTO_SEQ_TRAIL &&
      ({1'b0, state_reg.cnt} + 8'h01) == {1'b0, timing_o[2]})
      |=> state_reg.seq == cto_pkg::CTO_SEQ_IDLE && !clk_hs_drive_o;
  endproperty
  a_trail_exit: assert property (p_trail_exit)
    else $error("Trail state did not end after its interval.");

endmodule

// File: cto_pkg.sv
// Constants, types and lookup shared by the clock-lane timing override block.
// Assumes one core clock domain and an 8-bit register address space.
package cto_pkg;

  localparam logic [7:0] CTO_ADDR_CLK_PREPARE = 8'h40;
  localparam logic [7:0] CTO_ADDR_CLK_ZERO = 8'h41;
  localparam logic [7:0] CTO_ADDR_CLK_TRAIL = 8'h42;

  localparam int CTO_OVERRIDE_BIT = 7;
  localparam int CTO_VALUE_W = 7;
  localparam int CTO_NUM_IVL = 3;

  localparam logic [1:0] CTO_IDX_PREPARE = 2'h0;
  localparam logic [1:0] CTO_IDX_ZERO = 2'h1;
  localparam logic [1:0] CTO_IDX_TRAIL = 2'h2;
  localparam logic [1:0] CTO_IDX_NONE = 2'h3;

  localparam logic [7:0] CTO_READ_UNMAPPED = 8'h00;

  typedef enum logic [2:0] {
    CTO_RATE_400 = 3'h0,
    CTO_RATE_800 = 3'h1,
    CTO_RATE_1200 = 3'h2,
    CTO_RATE_1500 = 3'h3,
    CTO_RATE_1600 = 3'h4
  } cto_rate_t;

  // Index 0 prepare, 1 zero, 2 trail.
  typedef logic [2:0][6:0] cto_ivl_set_t;

  // Reset values correspond to the 800 Mbps lane rate.
  localparam cto_ivl_set_t CTO_AUTO_800 = {7'h0b, 7'h1b, 7'h05};
  localparam cto_ivl_set_t CTO_AUTO_400 = {7'h06, 7'h0e, 7'h03};
  localparam cto_ivl_set_t CTO_AUTO_1200 = {7'h10, 7'h28, 7'h07};
  localparam cto_ivl_set_t CTO_AUTO_1500 = {7'h13, 7'h32, 7'h09};
  localparam cto_ivl_set_t CTO_AUTO_1600 = {7'h14, 7'h35, 7'h0a};
  localparam cto_ivl_set_t CTO_RESET_IVL = CTO_AUTO_800;

  typedef struct packed {
    logic override;
    logic [6:0] value;
  } cto_ivl_reg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cto_bus_req_t;

  typedef enum logic [2:0] {
    CTO_SEQ_IDLE = 3'h0,
    CTO_SEQ_PREPARE = 3'h1,
    CTO_SEQ_ZERO = 3'h2,
    CTO_SEQ_HS = 3'h3,
    CTO_SEQ_TRAIL = 3'h4
  } cto_seq_t;

  typedef struct packed {
    cto_ivl_reg_t [2:0] ivl;
    logic [7:0] rdata;
    cto_seq_t seq;
    logic [6:0] cnt;
    logic lp_zero;
    logic hs_drive;
    logic toggle_en;
  } cto_state_t;

  // Codes outside the rate list fall back to the reset rate.
  function automatic cto_ivl_set_t cto_auto_lookup(input logic [2:0] rate);
    cto_ivl_set_t res;
    res = CTO_AUTO_800;
    case (rate)
      CTO_RATE_400: res = CTO_AUTO_400;
      CTO_RATE_1200: res = CTO_AUTO_1200;
      CTO_RATE_1500: res = CTO_AUTO_1500;
      CTO_RATE_1600: res = CTO_AUTO_1600;
      default: res = CTO_AUTO_800;
    endcase
    return res;
  endfunction

  function automatic logic [1:0] cto_addr_index(input logic [7:0] addr);
    logic [1:0] idx;
    idx = CTO_IDX_NONE;
    if (addr == CTO_ADDR_CLK_PREPARE)
    begin
      idx = CTO_IDX_PREPARE;
    end
    else if (addr == CTO_ADDR_CLK_ZERO)
    begin
      idx = CTO_IDX_ZERO;
    end
    else if (addr == CTO_ADDR_CLK_TRAIL)
    begin
      idx = CTO_IDX_TRAIL;
    end
    return idx;
  endfunction

endpackage

// File: cto_auto_timing.sv
// Automatic clock-lane interval table, registered from the selected lane rate.
// Assumes the rate select comes from logic on the same core clock.
`timescale 1ns/1ps
module cto_auto_timing (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [2:0] rate_i,
  output cto_pkg::cto_ivl_set_t auto_o
);

  cto_pkg::cto_ivl_set_t auto_reg;
  cto_pkg::cto_ivl_set_t auto_next;

  // A rate change reaches the table one enabled edge later.
  always_comb
  begin
    auto_next = cto_pkg::cto_auto_lookup(rate_i);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      auto_reg <= cto_pkg::CTO_RESET_IVL;
    end
    else if (ce_i)
    begin
      auto_reg <= auto_next;
    end
  end

  assign auto_o = auto_reg;

endmodule

// File: cto_rx_model.sv
// Receiver-side model of the clock lane: measures the prepare, zero and trail phases in core cycles.
// Assumes the lane state outputs are registered on the same core clock.
`timescale 1ns/1ps
module cto_rx_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic lp_zero_i,
  input wire logic hs_drive_i,
  input wire logic toggle_i,
  output logic [7:0] prep_len_o,
  output logic [7:0] zero_len_o,
  output logic [7:0] trail_len_o
);
  logic lp_q;
  logic hs_seen;
  // A new prepare phase clears the previous burst's figures.
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      lp_q <= 1'h0;
      hs_seen <= 1'h0;
      prep_len_o <= 8'h00;
      zero_len_o <= 8'h00;
      trail_len_o <= 8'h00;
    end
    else
    begin
      lp_q <= lp_zero_i;
      if (lp_zero_i && !lp_q)
      begin
        prep_len_o <= 8'h01;
        zero_len_o <= 8'h00;
        trail_len_o <= 8'h00;
        hs_seen <= 1'h0;
      end
      else if (lp_zero_i)
        prep_len_o <= prep_len_o + 8'h01;
      if (hs_drive_i && toggle_i)
        hs_seen <= 1'h1;
      else if (hs_drive_i && !hs_seen)
        zero_len_o <= zero_len_o + 8'h01;
      else if (hs_drive_i)
        trail_len_o <= trail_len_o + 8'h01;
    end
  end
endmodule

// File: tb_top.sv
// Self-checking bench for the clock-lane timing registers and sequencer.
// Assumes a 50 MHz core clock and a receiver model watching the lane outputs.
`timescale 1ns/1ps
module tb_top;
  logic clock_i;
  logic reset_i;
  logic ce_i;
  cto_pkg::cto_bus_req_t bus;
  logic [7:0] rdata;
  logic [2:0] rate;
  logic req;
  cto_pkg::cto_ivl_set_t timing;
  logic lp_zero;
  logic hs_drive;
  logic toggle;
  logic [7:0] p_len;
  logic [7:0] z_len;
  logic [7:0] t_len;
  logic [27:0] row;
  int fail_count;
  int n_checks;
  // Row: rate, write flag, address, write data, expected read.
  localparam logic [27:0] ROWS [23] = '{
    {3'h1, 1'h0, 8'h40, 8'h00, 8'h05}, {3'h1, 1'h0, 8'h41, 8'h00, 8'h1b},
    {3'h1, 1'h0, 8'h42, 8'h00, 8'h0b}, {3'h1, 1'h1, 8'h40, 8'h22, 8'h05},
    {3'h1, 1'h1, 8'h41, 8'h7f, 8'h1b}, {3'h0, 1'h0, 8'h40, 8'h00, 8'h03},
    {3'h0, 1'h0, 8'h41, 8'h00, 8'h0e}, {3'h0, 1'h0, 8'h42, 8'h00, 8'h06},
    {3'h2, 1'h0, 8'h40, 8'h00, 8'h07}, {3'h2, 1'h0, 8'h41, 8'h00, 8'h28},
    {3'h2, 1'h0, 8'h42, 8'h00, 8'h10}, {3'h3, 1'h0, 8'h40, 8'h00, 8'h09},
    {3'h3, 1'h0, 8'h41, 8'h00, 8'h32}, {3'h3, 1'h0, 8'h42, 8'h00, 8'h13},
    {3'h4, 1'h0, 8'h42, 8'h00, 8'h14}, {3'h7, 1'h0, 8'h41, 8'h00, 8'h1b},
    {3'h4, 1'h1, 8'h40, 8'h8a, 8'h8a}, {3'h4, 1'h1, 8'h41, 8'h85, 8'h85},
    {3'h4, 1'h1, 8'h42, 8'h83, 8'h83}, {3'h0, 1'h0, 8'h40, 8'h00, 8'h8a},
    {3'h1, 1'h1, 8'h40, 8'h11, 8'h05}, {3'h1, 1'h0, 8'h43, 8'h00, 8'h00},
    {3'h1, 1'h1, 8'h43, 8'hff, 8'h00}};

  cto_clock_lane_timing u_cto_clock_lane_timing (.clock_i(clock_i), .reset_i(reset_i),
    .ce_i(ce_i), .bus_i(bus), .bus_rdata_o(rdata), .lane_rate_i(rate),
    .hs_clk_req_i(req), .timing_o(timing), .clk_lp_zero_o(lp_zero),
    .clk_hs_drive_o(hs_drive), .clk_toggle_en_o(toggle));
  cto_rx_model u_cto_rx_model (.clock_i(clock_i), .reset_i(reset_i), .lp_zero_i(lp_zero),
    .hs_drive_i(hs_drive), .toggle_i(toggle), .prep_len_o(p_len), .zero_len_o(z_len),
    .trail_len_o(t_len));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus.wr <= 1'h1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clock_i);
    bus.wr <= 1'h0;
  endtask

  // Read data is checked in the one cycle where it stands, then checked back at 8'h00 the next cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    bus.rd <= 1'h1;
    bus.addr <= a;
    @(posedge clock_i);
    bus.rd <= 1'h0;
    #1;
    chk(rdata, e);
    @(posedge clock_i);
    #1;
    chk(rdata, 8'h00);
  endtask

  // Write then read with no idle cycle between, so the readback assertions see their pattern.
  task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clock_i);
    bus.wr <= 1'h1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clock_i);
    bus.wr <= 1'h0;
    bus.rd <= 1'h1;
    @(posedge clock_i);
    bus.rd <= 1'h0;
    #1;
    chk(rdata, e);
  endtask

  // The request is held into the high-speed phase so the exit is not cut short.
  task automatic run_seq(input logic [7:0] p, input logic [7:0] z, input logic [7:0] t);
    int n;
    @(posedge clock_i);
    req <= 1'h1;
    for (n = 0; n < 200 && toggle !== 1'h1; n++)
    begin
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    req <= 1'h0;
    for (n = 0; n < 200 && hs_drive !== 1'h0; n++)
    begin
      @(posedge clock_i);
      #1;
    end
    chk(p_len, p);
    chk(z_len, z);
    chk(t_len, t);
  endtask

  task automatic final_report;
    $display("Checks %0d, errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clock_i = 1'h0;
    forever #10 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (5000) @(posedge clock_i);
    fail_count++;
    final_report();
  end

  initial
  begin
    reset_i = 1'h1;
    ce_i = 1'h1;
    bus = '0;
    rate = 3'h1;
    req = 1'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'h0;
    for (int i = 0; i < 23; i++)
    begin
      row = ROWS[i];
      rate <= row[27:25];
      repeat (2) @(posedge clock_i);
      if (row[24])
        wr(row[23:16], row[15:8]);
      rd_chk(row[23:16], row[7:0]);
      if (row[23:16] !== 8'h43)
        chk({1'h0, timing[row[17:16]]}, {1'h0, row[6:0]});
    end
    run_seq(8'h05, 8'h05, 8'h03);
    wr(8'h40, 8'h80);
    run_seq(8'h01, 8'h05, 8'h03);
    @(posedge clock_i);
    reset_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'h0;
    rd_chk(8'h40, 8'h05);
    rd_chk(8'h41, 8'h1b);
    rd_chk(8'h42, 8'h0b);
    // A write while the clock enable is low must not land.
    @(posedge clock_i);
    ce_i <= 1'h0;
    wr(8'h42, 8'h8f);
    ce_i <= 1'h1;
    rd_chk(8'h42, 8'h0b);
    wr_rd_chk(8'h41, 8'h22, 8'h1b);
    wr_rd_chk(8'h42, 8'h0c, 8'h0b);
    wr_rd_chk(8'h40, 8'h85, 8'h85);
    run_seq(8'h05, 8'h1b, 8'h0b);
    final_report();
  end
endmodule
